// ---- hdl/nae_exec.sv ----
// Execution unit for immediate, table, arithmetic, logic, bit and compare ops
`timescale 1ns/1ps

module nae_exec (
   // Clock, reset and back-up return
   input  wire logic                clock_i,
   input  wire logic                rst_b_i,
   input  wire logic                backup_return_i,
   // Instruction issue
   input  wire logic                instr_valid_i,
   output logic                     instr_ready_o,
   input  wire nae_pkg::nae_op_t    op_i,
   input  wire logic [3:0]          imm_i,
   input  wire logic [5:0]          page_i,
   // Pointed memory nibble
   input  wire logic [3:0]          mem_rdata_i,
   output logic [3:0]               mem_wdata_o,
   output logic                     mem_we_o,
   // Table ROM
   output logic                     rom_req_o,
   output logic [13:0]              rom_addr_o,
   input  wire logic [9:0]          rom_rdata_i,
   // Return stack use
   output logic                     stack_push_o,
   output logic                     stack_pop_o,
   // Architectural state
   output logic [3:0]               acc_o,
   output logic                     carry_flag_o,
   output logic [3:0]               reg_b_o,
   output logic [2:0]               reg_d_o,
   output logic                     table_bank_o,
   output logic                     skip_next_o
);

   // All state of the unit
   typedef struct packed {
      nae_pkg::nae_state_t state;
      logic [3:0]          acc;
      logic                carry;
      logic [3:0]          b;
      logic [2:0]          d;
      logic                bank;
      logic                skip_pend;
      logic                load_run;
      logic [3:0]          mem_wdata;
      logic                mem_we;
      logic                rom_req;
      logic [13:0]         rom_addr;
      logic                push;
      logic                pop;
   } nae_st_t;

   // Registered state and its next value
   nae_st_t st_reg;
   nae_st_t st_next;

   // One-hot mask for a bit index
   function automatic logic [3:0] bit_mask(input logic [1:0] idx);
      logic [3:0] m;
      m = 4'h0;
      m[idx] = 1'b1;
      return m;
   endfunction : bit_mask

   // Table address: bank, page, D low three bits, accumulator
   function automatic logic [13:0] table_addr(
      input logic       bank,
      input logic [5:0] page,
      input logic [2:0] d,
      input logic [3:0] acc
   );
      return {bank, page, d, acc};
   endfunction : table_addr

   // Skip decision of the add-immediate, carry, test and compare ops
   function automatic logic skip_decision(
      input nae_pkg::nae_op_t op,
      input logic [3:0]       acc,
      input logic             carry,
      input logic [3:0]       mem,
      input logic [3:0]       imm,
      input logic             overflow
   );
      logic hit;
      hit = 1'b0;
      case (op)
         nae_pkg::NAE_OP_ADD_IMM: begin
            hit = !overflow;
         end
         nae_pkg::NAE_OP_SKIP_NC: begin
            hit = !carry;
         end
         nae_pkg::NAE_OP_BIT_TEST: begin
            hit = ((mem & bit_mask(imm[1:0])) == 4'h0);
         end
         nae_pkg::NAE_OP_CMP_MEM: begin
            hit = (acc == mem);
         end
         nae_pkg::NAE_OP_CMP_IMM: begin
            hit = (acc == imm);
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction : skip_decision

   logic [4:0] sum_mem;
   logic [4:0] sum_cy;
   logic [4:0] sum_imm;
   logic       do_exec;
   logic       is_load;
   logic       skip_hit;

   // Per-bit write data of the bit-set and bit-clear ops
   logic [3:0] set_word;
   logic [3:0] clr_word;

   for (genvar g = 0; g < 4; g++) begin : g_bit_write
      assign set_word[g] = mem_rdata_i[g] | (imm_i[1:0] == 2'(g));
      assign clr_word[g] = mem_rdata_i[g] & (imm_i[1:0] != 2'(g));
   end

   always_comb begin
      // Carry-out lands in bit 4 of each sum
      sum_mem = {1'b0, st_reg.acc} + {1'b0, mem_rdata_i};
      sum_cy  = {1'b0, st_reg.acc} + {1'b0, mem_rdata_i} + {4'h0, st_reg.carry};
      sum_imm = {1'b0, st_reg.acc} + {1'b0, imm_i};
      is_load = (op_i == nae_pkg::NAE_OP_IMM_LOAD);
      skip_hit = skip_decision(op_i, st_reg.acc, st_reg.carry, mem_rdata_i, imm_i, sum_imm[4]);
      // A pending skip or a load that follows a load does nothing
      do_exec = !st_reg.skip_pend && !(is_load && st_reg.load_run);
   end

   always_comb begin
      st_next        = st_reg;
      st_next.mem_we = 1'b0;
      st_next.push   = 1'b0;
      st_next.pop    = 1'b0;
      st_next.rom_req = 1'b0;
      // Back-up return lowers the bank before any op
      if (backup_return_i) begin
         st_next.bank = nae_pkg::BANK_LOW;
      end
      case (st_reg.state)
         nae_pkg::NAE_ST_IDLE: begin
            if (instr_valid_i) begin
               st_next.skip_pend = 1'b0;
               st_next.load_run  = is_load;
               if (do_exec) begin
                  case (op_i)
                     nae_pkg::NAE_OP_IMM_LOAD: begin
                        st_next.acc = imm_i;
                     end
                     nae_pkg::NAE_OP_TABLE_READ: begin
                        st_next.rom_addr = table_addr(st_reg.bank, page_i, st_reg.d, st_reg.acc);
                        st_next.rom_req  = 1'b1;
                        st_next.push     = 1'b1;
                        st_next.state    = nae_pkg::NAE_ST_TABLE_WAIT;
                     end
                     nae_pkg::NAE_OP_BANK_UPPER: begin
                        st_next.bank = nae_pkg::BANK_HIGH;
                     end
                     nae_pkg::NAE_OP_BANK_LOWER: begin
                        st_next.bank = nae_pkg::BANK_LOW;
                     end
                     nae_pkg::NAE_OP_ADD_MEM: begin
                        st_next.acc = sum_mem[3:0];
                     end
                     nae_pkg::NAE_OP_ADD_CARRY: begin
                        st_next.acc   = sum_cy[3:0];
                        st_next.carry = sum_cy[4];
                     end
                     nae_pkg::NAE_OP_ADD_IMM: begin
                        st_next.acc       = sum_imm[3:0];
                        st_next.skip_pend = skip_hit;
                     end
                     nae_pkg::NAE_OP_AND_MEM: begin
                        st_next.acc = st_reg.acc & mem_rdata_i;
                     end
                     nae_pkg::NAE_OP_OR_MEM: begin
                        st_next.acc = st_reg.acc | mem_rdata_i;
                     end
                     nae_pkg::NAE_OP_SET_CARRY: begin
                        st_next.carry = 1'b1;
                     end
                     nae_pkg::NAE_OP_CLR_CARRY: begin
                        st_next.carry = 1'b0;
                     end
                     nae_pkg::NAE_OP_SKIP_NC: begin
                        st_next.skip_pend = skip_hit;
                     end
                     nae_pkg::NAE_OP_COMPLEMENT: begin
                        st_next.acc = ~st_reg.acc;
                     end
                     nae_pkg::NAE_OP_ROTATE_R: begin
                        st_next.carry = st_reg.acc[0];
                        st_next.acc   = {st_reg.carry, st_reg.acc[3:1]};
                     end
                     nae_pkg::NAE_OP_BIT_SET: begin
                        st_next.mem_wdata = set_word;
                        st_next.mem_we    = 1'b1;
                     end
                     nae_pkg::NAE_OP_BIT_CLR: begin
                        st_next.mem_wdata = clr_word;
                        st_next.mem_we    = 1'b1;
                     end
                     nae_pkg::NAE_OP_BIT_TEST: begin
                        st_next.skip_pend = skip_hit;
                     end
                     nae_pkg::NAE_OP_CMP_MEM: begin
                        st_next.skip_pend = skip_hit;
                     end
                     nae_pkg::NAE_OP_CMP_IMM: begin
                        st_next.skip_pend = skip_hit;
                     end
                     default: begin
                        st_next.skip_pend = 1'b0;
                     end
                  endcase
               end
            end
         end
         nae_pkg::NAE_ST_TABLE_WAIT: begin
            // Word is taken in the same cycle as the request, while rom_req_o is high
            st_next.d     = {1'b0, rom_rdata_i[nae_pkg::TW_D_HI:nae_pkg::TW_D_LO]};
            st_next.b     = rom_rdata_i[nae_pkg::TW_B_HI:nae_pkg::TW_B_LO];
            st_next.acc   = rom_rdata_i[nae_pkg::TW_A_HI:nae_pkg::TW_A_LO];
            st_next.pop   = 1'b1;
            st_next.state = nae_pkg::NAE_ST_IDLE;
         end
         default: begin
            // Unreachable state recovers to idle
            st_next.state = nae_pkg::NAE_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         // Reset returns the table bank to the low pages
         st_reg.state     <= nae_pkg::NAE_ST_IDLE;
         st_reg.acc       <= nae_pkg::ACC_RST;
         st_reg.carry     <= nae_pkg::CARRY_RST;
         st_reg.b         <= nae_pkg::B_RST;
         st_reg.d         <= nae_pkg::D_RST;
         st_reg.bank      <= nae_pkg::BANK_LOW;
         st_reg.skip_pend <= 1'b0;
         st_reg.load_run  <= 1'b0;
         st_reg.mem_wdata <= 4'h0;
         st_reg.mem_we    <= 1'b0;
         st_reg.rom_req   <= 1'b0;
         st_reg.rom_addr  <= 14'h0;
         st_reg.push      <= 1'b0;
         st_reg.pop       <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Handshake and pulses
   assign instr_ready_o = (st_reg.state == nae_pkg::NAE_ST_IDLE);
   assign mem_wdata_o   = st_reg.mem_wdata;
   assign mem_we_o      = st_reg.mem_we;
   assign rom_req_o     = st_reg.rom_req;
   assign rom_addr_o    = st_reg.rom_addr;
   assign stack_push_o  = st_reg.push;
   assign stack_pop_o   = st_reg.pop;

   // Architectural state
   assign acc_o         = st_reg.acc;
   assign carry_flag_o  = st_reg.carry;
   assign reg_b_o       = st_reg.b;
   assign reg_d_o       = st_reg.d;
   assign table_bank_o  = st_reg.bank;
   assign skip_next_o   = st_reg.skip_pend;

endmodule : nae_exec

// ---- hdl/nae_pkg.sv ----
// Shared constants and types for the nibble ALU execution unit
package nae_pkg;

   // Operand widths
   localparam int NIB_W   = 4;
   localparam int ROMW_W  = 10;
   localparam int PAGE_W  = 6;
   localparam int D_W     = 3;
   localparam int ROMA_W  = 14;

   // Table word field positions
   localparam int TW_D_HI = 9;
   localparam int TW_D_LO = 8;
   localparam int TW_B_HI = 7;
   localparam int TW_B_LO = 4;
   localparam int TW_A_HI = 3;
   localparam int TW_A_LO = 0;

   // Reset values and table bank codes
   localparam logic [3:0] ACC_RST   = 4'h0;
   localparam logic [3:0] B_RST     = 4'h0;
   localparam logic [2:0] D_RST     = 3'h0;
   localparam logic       CARRY_RST = 1'b0;
   localparam logic       BANK_LOW  = 1'b0;
   localparam logic       BANK_HIGH = 1'b1;

   // Operations issued to the unit
   typedef enum logic [4:0] {
      NAE_OP_NOP,
      NAE_OP_IMM_LOAD,
      NAE_OP_TABLE_READ,
      NAE_OP_BANK_UPPER,
      NAE_OP_BANK_LOWER,
      NAE_OP_ADD_MEM,
      NAE_OP_ADD_CARRY,
      NAE_OP_ADD_IMM,
      NAE_OP_AND_MEM,
      NAE_OP_OR_MEM,
      NAE_OP_SET_CARRY,
      NAE_OP_CLR_CARRY,
      NAE_OP_SKIP_NC,
      NAE_OP_COMPLEMENT,
      NAE_OP_ROTATE_R,
      NAE_OP_BIT_SET,
      NAE_OP_BIT_CLR,
      NAE_OP_BIT_TEST,
      NAE_OP_CMP_MEM,
      NAE_OP_CMP_IMM
   } nae_op_t;

   typedef enum logic [1:0] {
      NAE_ST_IDLE,
      NAE_ST_TABLE_WAIT
   } nae_state_t;

endpackage : nae_pkg

// ---- sim/nae_exec_props.sv ----
// Port assertions for the nibble execution unit
`timescale 1ns/1ps
module nae_exec_props (
   // Watched ports
   input wire logic             clock_i,
   input wire logic             rst_b_i,
   input wire logic             backup_return_i,
   input wire logic             instr_valid_i,
   input wire logic             instr_ready_o,
   input wire nae_pkg::nae_op_t op_i,
   input wire logic [3:0]       imm_i,
   input wire logic [3:0]       mem_rdata_i,
   input wire logic             rom_req_o,
   input wire logic [9:0]       rom_rdata_i,
   input wire logic             stack_push_o,
   input wire logic             stack_pop_o,
   input wire logic [3:0]       acc_o,
   input wire logic             carry_flag_o,
   input wire logic             table_bank_o,
   input wire logic             skip_next_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   logic go;
   logic chain_reg;
   assign go = instr_valid_i && instr_ready_o && !skip_next_o;
   always_ff @(posedge clock_i) begin
      if (!rst_b_i)
         chain_reg <= 1'b0;
      else if (instr_valid_i && instr_ready_o)
         chain_reg <= (op_i == nae_pkg::NAE_OP_IMM_LOAD);
   end
   a_load_value: assert property (go && op_i == nae_pkg::NAE_OP_IMM_LOAD && !chain_reg
      |=> acc_o == $past(imm_i)) else $error("immediate load value wrong");
   a_table_slot: assert property (go && op_i == nae_pkg::NAE_OP_TABLE_READ
      |=> rom_req_o && stack_push_o && !instr_ready_o ##1 stack_pop_o) else $error("table stack slot wrong");
   a_table_word: assert property (rom_req_o
      |=> acc_o == $past(rom_rdata_i[3:0])) else $error("table word split wrong");
   a_bank_upper: assert property (go && op_i == nae_pkg::NAE_OP_BANK_UPPER
      |=> table_bank_o) else $error("upper bank not selected");
   a_backup_bank: assert property (backup_return_i |=> !table_bank_o) else $error("bank not lowered");
   a_add_mem: assert property (go && op_i == nae_pkg::NAE_OP_ADD_MEM
      |=> acc_o == 4'($past(acc_o) + $past(mem_rdata_i)) && $stable(carry_flag_o)) else $error("add memory wrong");
   a_carry_force: assert property (go && op_i inside {nae_pkg::NAE_OP_SET_CARRY, nae_pkg::NAE_OP_CLR_CARRY}
      |=> carry_flag_o == ($past(op_i) == nae_pkg::NAE_OP_SET_CARRY)) else $error("carry force wrong");
   a_cmp_imm: assert property (go && op_i == nae_pkg::NAE_OP_CMP_IMM
      |=> skip_next_o == ($past(acc_o) == $past(imm_i))) else $error("compare skip wrong");
   a_skip_quiet: assert property (instr_valid_i && instr_ready_o && skip_next_o
      |=> $stable(acc_o) && $stable(carry_flag_o) && !skip_next_o) else $error("skipped op changed state");
endmodule : nae_exec_props

bind nae_exec nae_exec_props u_nae_exec_props (.*);

// ---- sim/test_nibble_alu_instruction_exec.sv ----
// Random and corner-case test of the nibble execution unit
`timescale 1ns/1ps
module test_nibble_alu_instruction_exec;
   logic             clock_i = 1'b0, rst_b_i = 1'b0, backup_return_i = 1'b0, instr_valid_i = 1'b0;
   nae_pkg::nae_op_t op_i = nae_pkg::NAE_OP_NOP;
   logic [3:0]       imm_i = 4'h0, mem_rdata_i = 4'h0, mem_wdata_o, acc_o, reg_b_o, ea, eb;
   logic [5:0]       page_i = 6'h00;
   logic [9:0]       rom_rdata_i = 10'h000;
   logic [13:0]      rom_addr_o;
   logic [2:0]       reg_d_o, ed;
   logic             instr_ready_o, mem_we_o, rom_req_o, stack_push_o, stack_pop_o;
   logic             carry_flag_o, table_bank_o, skip_next_o, ec, ebk, esk, ech;
   logic [31:0]      rnd = 32'hd994b838;
   int               fails = 0, checks_done = 0;
   wire  [13:0]      st = {acc_o, reg_b_o, reg_d_o, table_bank_o, skip_next_o, carry_flag_o};
   nae_exec u_nae_exec (.clock_i(clock_i), .rst_b_i(rst_b_i), .backup_return_i(backup_return_i),
      .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o), .op_i(op_i), .imm_i(imm_i),
      .page_i(page_i), .mem_rdata_i(mem_rdata_i), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o),
      .rom_req_o(rom_req_o), .rom_addr_o(rom_addr_o), .rom_rdata_i(rom_rdata_i),
      .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o), .acc_o(acc_o), .carry_flag_o(carry_flag_o),
      .reg_b_o(reg_b_o), .reg_d_o(reg_d_o), .table_bank_o(table_bank_o), .skip_next_o(skip_next_o));
   initial begin
      forever #4 clock_i = ~clock_i;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rsx;
      {ea, eb, ed, ec, ebk, esk, ech} = '0;
   endtask : rsx
   // Issue one op and predict its effect
   task automatic issue(input nae_pkg::nae_op_t op, input logic [3:0] n);
      logic [3:0]  m, w;
      logic [13:0] ad;
      logic        we, tr;
      rnd = lfsr(rnd);
      m = rnd[3:0];
      ad = {ebk, rnd[9:4], ed, ea};
      {we, tr, w} = '0;
      @(posedge clock_i);
      op_i <= op;
      imm_i <= n;
      mem_rdata_i <= m;
      page_i <= rnd[9:4];
      rom_rdata_i <= rnd[19:10];
      instr_valid_i <= 1'b1;
      if (esk) esk = 1'b0;
      else case (op)
         nae_pkg::NAE_OP_IMM_LOAD: if (!ech) ea = n;
         nae_pkg::NAE_OP_TABLE_READ: begin
            tr = 1'b1;
            {ed, eb, ea} = {1'b0, rnd[19:10]};
         end
         nae_pkg::NAE_OP_BANK_UPPER: ebk = 1'b1;
         nae_pkg::NAE_OP_BANK_LOWER: ebk = 1'b0;
         nae_pkg::NAE_OP_ADD_MEM: ea = ea + m;
         nae_pkg::NAE_OP_ADD_CARRY: {ec, ea} = ea + m + ec;
         nae_pkg::NAE_OP_ADD_IMM: begin
            {esk, ea} = ea + n;
            esk = !esk;
         end
         nae_pkg::NAE_OP_AND_MEM: ea = ea & m;
         nae_pkg::NAE_OP_OR_MEM: ea = ea | m;
         nae_pkg::NAE_OP_SET_CARRY: ec = 1'b1;
         nae_pkg::NAE_OP_CLR_CARRY: ec = 1'b0;
         nae_pkg::NAE_OP_SKIP_NC: esk = !ec;
         nae_pkg::NAE_OP_COMPLEMENT: ea = ~ea;
         nae_pkg::NAE_OP_ROTATE_R: {ea, ec} = {ec, ea};
         nae_pkg::NAE_OP_BIT_SET: {we, w} = {1'b1, m | (4'h1 << n[1:0])};
         nae_pkg::NAE_OP_BIT_CLR: {we, w} = {1'b1, m & ~(4'h1 << n[1:0])};
         nae_pkg::NAE_OP_BIT_TEST: esk = !m[n[1:0]];
         nae_pkg::NAE_OP_CMP_MEM: esk = (ea == m);
         nae_pkg::NAE_OP_CMP_IMM: esk = (ea == n);
         default: ;
      endcase
      ech = (op == nae_pkg::NAE_OP_IMM_LOAD);
      @(posedge clock_i);
      instr_valid_i <= 1'b0;
      #1;
      chk("bit write", {we, we ? w : 4'h0}, {mem_we_o, we ? mem_wdata_o : 4'h0});
      chk("table start", {tr, tr, !tr}, {rom_req_o, stack_push_o, instr_ready_o});
      if (tr) begin
         chk("table address", ad, rom_addr_o);
         @(posedge clock_i);
         #1;
         chk("stack release", 1'b1, stack_pop_o);
      end
      chk("state", {ea, eb, ed, ebk, esk, ec}, st);
   endtask : issue
   task automatic run_random(input int cnt);
      for (int i = 0; i < cnt; i++) begin
         issue(nae_pkg::nae_op_t'(5'(rnd[31:24] % 8'd20)), rnd[23:20]);
      end
   endtask : run_random
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   initial begin
      #100000;
      fails++;
      final_report();
   end
   initial begin
      rsx();
      repeat (10) @(posedge clock_i);
      rst_b_i <= 1'b1;
      #1 chk("reset", 14'h0, st);
      chk("reset ready", 14'h1, {13'h0, instr_ready_o});
      for (int k = 0; k < 3; k++) issue(nae_pkg::NAE_OP_IMM_LOAD, 4'(k + 5));
      issue(nae_pkg::NAE_OP_ADD_IMM, 4'hf);
      for (int t = 0; t < 20; t++) issue(nae_pkg::nae_op_t'(t), rnd[23:20]);
      run_random(250);
      issue(nae_pkg::NAE_OP_BANK_UPPER, 4'h0);
      @(posedge clock_i);
      backup_return_i <= 1'b1;
      @(posedge clock_i);
      backup_return_i <= 1'b0;
      ebk = 1'b0;
      #1 chk("backup bank", ebk, table_bank_o);
      run_random(250);
      issue(nae_pkg::NAE_OP_BANK_UPPER, 4'h0);
      @(posedge clock_i);
      rst_b_i <= 1'b0;
      @(posedge clock_i);
      rst_b_i <= 1'b1;
      rsx();
      #1 chk("mid reset", 14'h0, st);
      run_random(100);
      final_report();
   end
endmodule : test_nibble_alu_instruction_exec
